//--- tsl_cfg.svh
// Constants for the torque and speed limit logic.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef TSL_CFG_SVH
`define TSL_CFG_SVH

// ****************************************
// Torque scaling
// ****************************************
// Torque values in 0.1 % steps, 100.0 % is one full unit
`define TSL_TRQ_FULL_SCALE 15'h03E8
`define TSL_TRQ_W 16
`define TSL_TRQ_PROD_W 30

// ****************************************
// Speed ceilings
// ****************************************
// 3000.00 r/min or mm/s, held in 0.01 steps
`define TSL_SPD_CEIL_RST 31'h0004_93E0
// 2147483647 command unit/s
`define TSL_SPD_EXT_RST 31'h7FFF_FFFF
`define TSL_SPD_W 32

// ****************************************
// Status word layout
// ****************************************
`define TSL_STAT1_TLIM_BIT 13
`define TSL_STAT2_VLIM_BIT 4
`define TSL_STAT_W 16

`endif

//--- tsl_pkg.sv
// Types shared by the torque and speed limit logic.
// Assumes tsl_cfg.svh sits in the include path.
`include "tsl_cfg.svh"

package tsl_pkg;

	// ****************************************
	// Limit source, one-hot
	// ****************************************
	typedef enum logic [3:0] {
		TSL_SRC_FIXED = 4'h1,
		TSL_SRC_ANALOG = 4'h2,
		TSL_SRC_SECOND = 4'h4,
		TSL_SRC_LOWER = 4'h8
	} tsl_src_t;

	// ****************************************
	// Registered state of the top module
	// ****************************************
	typedef struct packed {
		logic [`TSL_SPD_W-2:0] spd_ceil;
		logic [`TSL_SPD_W-2:0] spd_ext;
		tsl_src_t src;
		logic [`TSL_TRQ_W-2:0] fwd_lim;
		logic [`TSL_TRQ_W-2:0] rev_lim;
		logic [`TSL_SPD_W-2:0] spd_lim;
		logic signed [`TSL_TRQ_W-1:0] trq_out;
		logic trq_flag;
		logic spd_flag;
		logic [`TSL_STAT_W-1:0] stat1;
		logic [`TSL_STAT_W-1:0] stat2;
	} tsl_state_t;

endpackage

//--- tsl_unit_conv.sv
// Torque ceiling unit conversion and motor maximum clamp.
// Assumes all values are in 0.1 % steps and settle within one clock.
`include "tsl_cfg.svh"

module tsl_unit_conv
	import tsl_pkg::*;
#(
	parameter int W = `TSL_TRQ_W - 1
) (
	input wire logic [W-1:0] value_i,
	input wire logic unit_max_i,
	input wire logic [W-1:0] motor_max_i,
	output logic [W-1:0] ceiling_o
);

	logic [2*W-1:0] prod;
	logic [2*W-1:0] scaled;
	logic [2*W-1:0] rated;

	// ****************************************
	// Conversion
	// ****************************************
	always_comb begin
		prod = value_i * motor_max_i;
		scaled = prod / {{W{1'b0}}, `TSL_TRQ_FULL_SCALE};
		if (unit_max_i) begin
			rated = scaled;
		end else begin
			rated = {{W{1'b0}}, value_i};
		end
		// clamp to motor max
		// Full-width compare, a large scaled value must not wrap under the max
		if (rated > {{W{1'b0}}, motor_max_i}) begin
			ceiling_o = motor_max_i;
		end else begin
			ceiling_o = rated[W-1:0];
		end
	end

endmodule

//--- tsl_dir_clamp.sv
// Direction-aware clamp of a signed value against two magnitudes.
// Assumes the limits are magnitudes one bit narrower than the value.
module tsl_dir_clamp
	import tsl_pkg::*;
#(
	parameter int W = 16
) (
	input wire logic signed [W-1:0] value_i,
	input wire logic [W-2:0] pos_lim_i,
	input wire logic [W-2:0] neg_lim_i,
	output logic signed [W-1:0] clamped_o,
	output logic at_pos_o,
	output logic at_neg_o
);

	logic signed [W:0] v;
	logic signed [W:0] p;
	logic signed [W:0] n;

	// ****************************************
	// Compare and clamp
	// ****************************************
	// One extra bit keeps the negated limit from wrapping
	always_comb begin
		v = {value_i[W-1], value_i};
		p = {2'b00, pos_lim_i};
		n = -{2'b00, neg_lim_i};
		at_pos_o = (v >= p) && !value_i[W-1];
		at_neg_o = (v <= n) && (value_i[W-1] || (neg_lim_i == '0));
		if (at_pos_o) begin
			clamped_o = p[W-1:0];
		end else if (at_neg_o) begin
			clamped_o = n[W-1:0];
		end else begin
			clamped_o = value_i;
		end
	end

endmodule

//--- tsl_limit_top.sv
// Torque and speed limit logic of the servo amplifier.
// Assumes all inputs are synchronous to mclk_i and hold for a cycle.
//
// Function
// - Network variant raises torque flag and status word one bit 13 at ceiling.
// - Analog variant raises torque flag at any selected ceiling source.
// - Any ceiling above motor maximum torque is clamped to that maximum.
// - Both fixed ceilings zero means no torque is produced.
// - Forward ceiling bounds positive torque, CCW drive and CW braking.
// - Reverse ceiling bounds negative torque, CW drive and CCW braking.
// - Fixed forward and reverse ceilings always bound torque, any source.
// - Internal select compares second ceiling with fixed ones, lower wins.
// - Two selects choose fixed, analog, second, or lower of analog and second.
// - Fixed ceiling below chosen source value is used for that direction.
// - Analog ceiling input is ignored in torque control mode.
// - Ceilings in rated-torque units, maximum-torque units when unit select set.
// - Speed limit only in torque mode, only in commanded direction.
// - Cyclic controller writes of speed ceiling overwrite tool writes.
// - Speed ceiling comes from setting, default 3000.00.
// - Unit select one uses extended speed ceiling, default 2147483647.
// - Speed flag and status word two bit 4 raised at speed ceiling.
`include "tsl_cfg.svh"

module tsl_limit_top
	import tsl_pkg::*;
#(
	parameter int TW = `TSL_TRQ_W,
	parameter int SW = `TSL_SPD_W,
	parameter int STW = `TSL_STAT_W
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Variant and mode
	input wire logic network_variant_i,
	input wire logic torque_mode_i,
	// Torque ceiling settings, 0.1 % steps
	input wire logic [TW-2:0] forward_ceiling_param_i,
	input wire logic [TW-2:0] reverse_ceiling_param_i,
	input wire logic [TW-2:0] second_ceiling_param_i,
	input wire logic [TW-2:0] analog_ceiling_input_i,
	input wire logic [TW-2:0] motor_max_torque_i,
	input wire logic ceiling_unit_select_i,
	input wire logic external_ceiling_select_i,
	input wire logic internal_ceiling_select_i,
	// Torque command and feedback
	input wire logic signed [TW-1:0] torque_cmd_i,
	input wire logic signed [TW-1:0] motor_torque_i,
	// Speed ceiling writes
	input wire logic tool_speed_wr_i,
	input wire logic [SW-2:0] tool_speed_val_i,
	input wire logic ctrl_speed_wr_i,
	input wire logic [SW-2:0] ctrl_speed_val_i,
	input wire logic speed_obj_mapped_i,
	input wire logic ext_speed_wr_i,
	input wire logic [SW-2:0] ext_speed_val_i,
	input wire logic speed_unit_select_i,
	// Speed feedback
	input wire logic signed [SW-1:0] motor_speed_i,
	// Results
	output logic signed [TW-1:0] torque_out_o,
	output logic [TW-2:0] forward_limit_o,
	output logic [TW-2:0] reverse_limit_o,
	output logic [3:0] limit_source_o,
	output logic [SW-2:0] speed_limit_o,
	output logic torque_limiting_flag_o,
	output logic speed_limiting_flag_o,
	output logic [STW-1:0] first_output_status_word_o,
	output logic [STW-1:0] second_output_status_word_o
);

	// ****************************************
	// State
	// ****************************************
	tsl_state_t s_q;
	tsl_state_t s_d;

	// ****************************************
	// Ceiling conversion
	// ****************************************
	// Index 0 forward, 1 reverse, 2 second, 3 analog
	logic [TW-2:0] raw_ceil [4];
	logic [TW-2:0] conv_ceil [4];

	always_comb begin
		raw_ceil[0] = forward_ceiling_param_i;
		raw_ceil[1] = reverse_ceiling_param_i;
		raw_ceil[2] = second_ceiling_param_i;
		raw_ceil[3] = analog_ceiling_input_i;
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_conv
			tsl_unit_conv #(
				.W(TW - 1)
			) u_conv (
				.value_i(raw_ceil[gi]),
				.unit_max_i(ceiling_unit_select_i),
				.motor_max_i(motor_max_torque_i),
				.ceiling_o(conv_ceil[gi])
			);
		end
	endgenerate

	// ****************************************
	// Torque clamp on registered limits
	// ****************************************
	logic signed [TW-1:0] trq_clamped;

	tsl_dir_clamp #(
		.W(TW)
	) u_trq_clamp (
		.value_i(torque_cmd_i),
		.pos_lim_i(s_q.fwd_lim),
		.neg_lim_i(s_q.rev_lim),
		.clamped_o(trq_clamped),
		.at_pos_o(),
		.at_neg_o()
	);

	// ****************************************
	// Feedback compare against limits
	// ****************************************
	logic fb_at_pos;
	logic fb_at_neg;

	tsl_dir_clamp #(
		.W(TW)
	) u_fb_cmp (
		.value_i(motor_torque_i),
		.pos_lim_i(s_q.fwd_lim),
		.neg_lim_i(s_q.rev_lim),
		.clamped_o(),
		.at_pos_o(fb_at_pos),
		.at_neg_o(fb_at_neg)
	);

	logic spd_at_pos;
	logic spd_at_neg;

	// Same magnitude both ways; direction picked below
	tsl_dir_clamp #(
		.W(SW)
	) u_spd_cmp (
		.value_i(motor_speed_i),
		.pos_lim_i(s_q.spd_lim),
		.neg_lim_i(s_q.spd_lim),
		.clamped_o(),
		.at_pos_o(spd_at_pos),
		.at_neg_o(spd_at_neg)
	);

	// ****************************************
	// Next-state logic
	// ****************************************
	logic use_ext;
	logic use_int;
	logic [TW-2:0] chosen;
	logic [TW-2:0] fwd_eff;
	logic [TW-2:0] rev_eff;
	logic spd_hit;
	logic trq_hit;

	always_comb begin
		s_d = s_q;

		if (speed_obj_mapped_i && ctrl_speed_wr_i) begin
			s_d.spd_ceil = ctrl_speed_val_i;
		end else if (tool_speed_wr_i) begin
			s_d.spd_ceil = tool_speed_val_i;
		end

		if (ext_speed_wr_i) begin
			s_d.spd_ext = ext_speed_val_i;
		end

		use_ext = external_ceiling_select_i && !torque_mode_i;
		use_int = internal_ceiling_select_i;

		case ({use_int, use_ext})
			2'b00: s_d.src = TSL_SRC_FIXED;
			2'b01: s_d.src = TSL_SRC_ANALOG;
			2'b10: s_d.src = TSL_SRC_SECOND;
			2'b11: s_d.src = TSL_SRC_LOWER;
			default: s_d.src = TSL_SRC_FIXED;
		endcase

		case (s_d.src)
			TSL_SRC_ANALOG: chosen = conv_ceil[3];
			TSL_SRC_SECOND: chosen = conv_ceil[2];
			TSL_SRC_LOWER: begin
				if (conv_ceil[3] < conv_ceil[2]) begin
					chosen = conv_ceil[3];
				end else begin
					chosen = conv_ceil[2];
				end
			end
			default: chosen = conv_ceil[0];
		endcase

		fwd_eff = conv_ceil[0];
		rev_eff = conv_ceil[1];
		if (s_d.src != TSL_SRC_FIXED) begin
			if (chosen < fwd_eff) begin
				fwd_eff = chosen;
			end
			if (chosen < rev_eff) begin
				rev_eff = chosen;
			end
		end
		s_d.fwd_lim = fwd_eff;
		s_d.rev_lim = rev_eff;

		if (speed_unit_select_i) begin
			s_d.spd_lim = s_q.spd_ext;
		end else begin
			s_d.spd_lim = s_q.spd_ceil;
		end

		spd_hit = torque_mode_i &&
			((!torque_cmd_i[TW-1] && (torque_cmd_i != '0) && spd_at_pos) ||
			(torque_cmd_i[TW-1] && spd_at_neg));

		if (s_q.fwd_lim == '0 && s_q.rev_lim == '0) begin
			s_d.trq_out = '0;
		end else if (spd_hit) begin
			// Cutting torque is crude but never drives past the limit
			s_d.trq_out = '0;
		end else begin
			s_d.trq_out = trq_clamped;
		end

		trq_hit = fb_at_pos || fb_at_neg;
		s_d.trq_flag = trq_hit;
		s_d.spd_flag = spd_hit;

		// status bit only on network variant
		s_d.stat1 = '0;
		s_d.stat1[`TSL_STAT1_TLIM_BIT] = trq_hit && network_variant_i;
		s_d.stat2 = '0;
		s_d.stat2[`TSL_STAT2_VLIM_BIT] = spd_hit;
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_q.spd_ceil <= `TSL_SPD_CEIL_RST;
			s_q.spd_ext <= `TSL_SPD_EXT_RST;
			s_q.src <= TSL_SRC_FIXED;
			// Zero limits keep torque off until settings land
			s_q.fwd_lim <= '0;
			s_q.rev_lim <= '0;
			s_q.spd_lim <= `TSL_SPD_CEIL_RST;
			s_q.trq_out <= '0;
			s_q.trq_flag <= 1'b0;
			s_q.spd_flag <= 1'b0;
			s_q.stat1 <= '0;
			s_q.stat2 <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************
	always_comb begin
		torque_out_o = s_q.trq_out;
		forward_limit_o = s_q.fwd_lim;
		reverse_limit_o = s_q.rev_lim;
		limit_source_o = s_q.src;
		speed_limit_o = s_q.spd_lim;
		torque_limiting_flag_o = s_q.trq_flag;
		speed_limiting_flag_o = s_q.spd_flag;
		first_output_status_word_o = s_q.stat1;
		second_output_status_word_o = s_q.stat2;
	end

endmodule

//--- tsl_motor_model.sv
// Motor stand-in: measured torque follows the limited torque output.
// Assumes the same clock as the limit logic; speed comes from the bench.
module tsl_motor_model
	import tsl_pkg::*;
(
	input wire logic mclk_i,
	input wire logic signed [15:0] torque_i,
	output logic signed [15:0] torque_o
);
	timeunit 1ns;
	timeprecision 1ns;
	// One cycle of lag, like a current loop settling
	always @(posedge mclk_i) begin
		torque_o <= torque_i;
	end
endmodule

//--- tsl_limit_properties.sv
// Assertions on the ports of the torque and speed limit logic.
// Assumes one clock domain; bound to every instance of the top module.
module tsl_limit_properties
	import tsl_pkg::*;
(
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic network_variant_i,
	input wire logic torque_mode_i,
	input wire logic [14:0] forward_ceiling_param_i,
	input wire logic ceiling_unit_select_i,
	input wire logic external_ceiling_select_i,
	input wire logic internal_ceiling_select_i,
	input wire logic signed [15:0] torque_cmd_i,
	input wire logic signed [15:0] motor_torque_i,
	input wire logic tool_speed_wr_i,
	input wire logic ctrl_speed_wr_i,
	input wire logic [30:0] ctrl_speed_val_i,
	input wire logic speed_obj_mapped_i,
	input wire logic speed_unit_select_i,
	input wire logic signed [31:0] motor_speed_i,
	input wire logic signed [15:0] torque_out_o,
	input wire logic [14:0] forward_limit_o,
	input wire logic [14:0] reverse_limit_o,
	input wire logic [3:0] limit_source_o,
	input wire logic [30:0] speed_limit_o,
	input wire logic torque_limiting_flag_o,
	input wire logic speed_limiting_flag_o,
	input wire logic [15:0] first_output_status_word_o,
	input wire logic [15:0] second_output_status_word_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic t_hit;
	logic s_hit;
	int tq;
	int sp;
	assign tq = int'(motor_torque_i);
	assign sp = int'(motor_speed_i);
	assign t_hit = (tq >= 0 && tq >= int'(forward_limit_o)) || tq <= -int'(reverse_limit_o);
	assign s_hit = torque_mode_i && ((torque_cmd_i > 0 && sp >= int'(speed_limit_o))
		|| (torque_cmd_i < 0 && sp <= -int'(speed_limit_o)));
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_both_sel;
		external_ceiling_select_i && internal_ceiling_select_i && !torque_mode_i;
	endsequence
	sequence s_ctrl_race;
		(speed_obj_mapped_i && ctrl_speed_wr_i && tool_speed_wr_i && !speed_unit_select_i) ##1 !speed_unit_select_i;
	endsequence
	a_src_fixed: assert property (!external_ceiling_select_i && !internal_ceiling_select_i |=>
		limit_source_o == 4'h1) else $error("fixed source not chosen");
	a_src_lower: assert property (s_both_sel |=> limit_source_o == 4'h8) else $error("lower source not chosen");
	a_analog_ignored: assert property (external_ceiling_select_i && !internal_ceiling_select_i && torque_mode_i
		|=> limit_source_o == 4'h1) else $error("analog used in torque mode");
	a_fwd_bound: assert property (!ceiling_unit_select_i |=> forward_limit_o <= $past(forward_ceiling_param_i))
		else $error("forward limit above setting");
	a_trq_span: assert property (1'b1 |=> int'(torque_out_o) <= int'($past(forward_limit_o))
		&& int'(torque_out_o) >= -int'($past(reverse_limit_o))) else $error("torque outside limits");
	a_trq_zero: assert property (forward_limit_o == 15'h0000 && reverse_limit_o == 15'h0000 |=>
		torque_out_o == 16'h0000) else $error("torque with zero limits");
	a_trq_pass: assert property (!torque_mode_i && int'(torque_cmd_i) < int'(forward_limit_o)
		&& int'(torque_cmd_i) > -int'(reverse_limit_o) |=> torque_out_o == $past(torque_cmd_i))
		else $error("command altered inside limits");
	a_tflag_track: assert property (1'b1 |=> torque_limiting_flag_o == $past(t_hit))
		else $error("torque flag wrong");
	a_stat1_map: assert property (1'b1 |=> first_output_status_word_o
		== {2'b00, torque_limiting_flag_o & $past(network_variant_i), 13'h0000}) else $error("status one wrong");
	a_spd_track: assert property (1'b1 |=> speed_limiting_flag_o == $past(s_hit))
		else $error("speed flag wrong");
	a_stat2_map: assert property (second_output_status_word_o == {11'h000, speed_limiting_flag_o, 4'h0})
		else $error("status two wrong");
	a_ctrl_wins: assert property (s_ctrl_race |=> speed_limit_o == $past(ctrl_speed_val_i, 2))
		else $error("controller write lost");
endmodule
bind tsl_limit_top tsl_limit_properties u_props (.*);

//--- tsl_tb.sv
// Self-checking bench for the torque and speed limit logic.
// Assumes the motor stand-in feeds torque back; speed is driven here.
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin errors++; \
	$display("wrong value %s expected %0h seen %0h", nm, exp, got); end end
module testbench
	import tsl_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk_i, rst_n_i, network_variant_i, torque_mode_i, ceiling_unit_select_i;
	logic external_ceiling_select_i, internal_ceiling_select_i, tool_speed_wr_i, ctrl_speed_wr_i;
	logic speed_obj_mapped_i, ext_speed_wr_i, speed_unit_select_i, torque_limiting_flag_o, speed_limiting_flag_o;
	logic [14:0] forward_ceiling_param_i, reverse_ceiling_param_i, second_ceiling_param_i;
	logic [14:0] analog_ceiling_input_i, motor_max_torque_i, forward_limit_o, reverse_limit_o;
	logic signed [15:0] torque_cmd_i, motor_torque_i, torque_out_o;
	logic [30:0] tool_speed_val_i, ctrl_speed_val_i, ext_speed_val_i, speed_limit_o;
	logic signed [31:0] motor_speed_i;
	logic [3:0] limit_source_o;
	logic [15:0] first_output_status_word_o, second_output_status_word_o;
	int errors = 0;
	int n_checks = 0;
	// Expected per select case: none, analog, second, both, analog in torque mode
	logic [14:0] ef[5] = '{15'h0258, 15'h01F4, 15'h012C, 15'h012C, 15'h0258};
	logic [14:0] er[5] = '{15'h0190, 15'h0190, 15'h012C, 15'h012C, 15'h0190};
	logic [3:0] es[5] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h1};
	tsl_limit_top dut (.*);
	tsl_motor_model motor (.mclk_i(mclk_i), .torque_i(torque_out_o), .torque_o(motor_torque_i));
	always #10 mclk_i = ~mclk_i;
	task automatic go(int n);
		repeat (n) @(posedge mclk_i);
		#1;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic t_reset;
		`CHK("source", 4'h1, limit_source_o)
		`CHK("speed limit", 31'h0004_93E0, speed_limit_o)
		rst_n_i = 1;
		speed_unit_select_i = 1;
		go(2);
		`CHK("ext limit", 31'h7FFF_FFFF, speed_limit_o)
		ext_speed_wr_i = 1;
		ext_speed_val_i = 31'h0000_1388;
		go(1);
		ext_speed_wr_i = 0;
		go(1);
		`CHK("ext write", 31'h0000_1388, speed_limit_o)
		speed_unit_select_i = 0;
	endtask
	task automatic t_select;
		forward_ceiling_param_i = 15'h0258;
		reverse_ceiling_param_i = 15'h0190;
		for (int i = 0; i < 5; i++) begin
			external_ceiling_select_i = i[0] | i[2];
			internal_ceiling_select_i = i[1];
			torque_mode_i = i[2];
			go(2);
			`CHK("source", es[i], limit_source_o)
			`CHK("fwd", ef[i], forward_limit_o)
			`CHK("rev", er[i], reverse_limit_o)
		end
		{external_ceiling_select_i, internal_ceiling_select_i, torque_mode_i} = 3'b000;
	endtask
	task automatic t_clamp;
		forward_ceiling_param_i = 15'h09C4;
		go(2);
		`CHK("fwd max", 15'h07D0, forward_limit_o)
		forward_ceiling_param_i = 15'h01F4;
		ceiling_unit_select_i = 1;
		go(2);
		`CHK("fwd unit", 15'h03E8, forward_limit_o)
		forward_ceiling_param_i = 15'h4268;
		go(2);
		`CHK("fwd wrap", 15'h07D0, forward_limit_o)
		forward_ceiling_param_i = 15'h01F4;
		ceiling_unit_select_i = 0;
		reverse_ceiling_param_i = 15'h012C;
	endtask
	task automatic t_torque;
		torque_cmd_i = 16'h0320;
		go(4);
		`CHK("trq", 16'h01F4, torque_out_o)
		`CHK("tflag", 1'b1, torque_limiting_flag_o)
		`CHK("stat1", 16'h2000, first_output_status_word_o)
		network_variant_i = 0;
		torque_cmd_i = 16'hFCE0;
		go(4);
		`CHK("trq", 16'hFED4, torque_out_o)
		`CHK("tflag", 1'b1, torque_limiting_flag_o)
		`CHK("stat1", 16'h0000, first_output_status_word_o)
		torque_cmd_i = 16'h0064;
		go(4);
		`CHK("tflag", 1'b0, torque_limiting_flag_o)
		{forward_ceiling_param_i, reverse_ceiling_param_i} = 30'h0000_0000;
		go(4);
		`CHK("trq", 16'h0000, torque_out_o)
		forward_ceiling_param_i = 15'h01F4;
		reverse_ceiling_param_i = 15'h012C;
		network_variant_i = 1;
	endtask
	task automatic t_speed;
		torque_mode_i = 1;
		tool_speed_wr_i = 1;
		tool_speed_val_i = 31'h0000_03E8;
		go(1);
		tool_speed_wr_i = 0;
		motor_speed_i = 32'h0000_03E8;
		go(3);
		`CHK("vflag", 1'b1, speed_limiting_flag_o)
		`CHK("stat2", 16'h0010, second_output_status_word_o)
		torque_cmd_i = 16'hFF9C;
		go(2);
		`CHK("vflag", 1'b0, speed_limiting_flag_o)
		motor_speed_i = 32'hFFFF_FC18;
		go(2);
		`CHK("vflag", 1'b1, speed_limiting_flag_o)
		torque_mode_i = 0;
		go(2);
		`CHK("vflag", 1'b0, speed_limiting_flag_o)
		speed_obj_mapped_i = 1;
		{ctrl_speed_wr_i, tool_speed_wr_i} = 2'b11;
		ctrl_speed_val_i = 31'h0000_07D0;
		go(1);
		{ctrl_speed_wr_i, tool_speed_wr_i, speed_obj_mapped_i} = 3'b100;
		ctrl_speed_val_i = 31'h0000_0BB8;
		go(1);
		ctrl_speed_wr_i = 0;
		go(2);
		`CHK("ctrl wins", 31'h0000_07D0, speed_limit_o)
	endtask
	initial begin
		mclk_i = 0;
		rst_n_i = 0;
		{network_variant_i, torque_mode_i, ceiling_unit_select_i, speed_unit_select_i} = 4'h8;
		{external_ceiling_select_i, internal_ceiling_select_i, speed_obj_mapped_i} = 3'b000;
		{tool_speed_wr_i, ctrl_speed_wr_i, ext_speed_wr_i} = 3'b000;
		{forward_ceiling_param_i, reverse_ceiling_param_i} = 30'h0000_0000;
		second_ceiling_param_i = 15'h012C;
		analog_ceiling_input_i = 15'h01F4;
		motor_max_torque_i = 15'h07D0;
		torque_cmd_i = 16'h0000;
		{tool_speed_val_i, ctrl_speed_val_i, ext_speed_val_i} = 93'h0;
		motor_speed_i = 32'h0000_0000;
		go(20);
		t_reset;
		t_select;
		t_clamp;
		t_torque;
		t_speed;
		tally_and_finish;
	end
	// Watchdog: the scenarios need under two hundred cycles
	initial begin
		repeat (3000) @(posedge mclk_i);
		errors++;
		tally_and_finish;
	end
endmodule
